// ---- design/ssp_pkg.sv ----
package ssp_pkg;
  typedef enum logic [1:0] {SSP_IDLE, SSP_HDR, SSP_DATA, SSP_DONE} ssp_state_t;
  typedef struct packed {
    logic sclk;
    logic sel_n;
    logic sdio;
  } ssp_pins_t;
endpackage

// ---- design/ssp_port.sv ----
`timescale 1ns/1ps
`include "ssp_regs.svh"
// Operation
// - a burst is exactly the interval while serial_select_n is low
// - incoming data is sampled on each of the first 24 rising serial clock edges in a burst; later edges are ignored
// - all incoming data is taken from the bidirectional data line
// - three-wire mode drives read data onto the bidirectional line
// - three-wire mode keeps serial_out_line high impedance always
// - four-wire mode presents read data on serial_out_line
// - serial_out_line released whenever select is deasserted
// - chip enable low resets registers; global_powerdown_bit keeps contents
module ssp_port (
  input  wire logic  clk,                  // system clock, 10 MHz
  input  wire logic  sys_rst,              // synchronous reset, active high
  input  wire logic  chip_en,              // chip enable pin, low clears registers
  input  wire logic  serial_clk,           // serial clock pin
  input  wire logic  serial_select_n,      // burst select pin, active low
  input  wire logic  sdio_in,              // data line input level
  output logic       sdio_out,             // data line drive value
  output logic       sdio_oe,              // data line drive enable
  output logic       serial_out_line,      // separate output value
  output logic       serial_out_oe,        // separate output enable
  output logic       global_powerdown_bit, // power-down, registers kept
  output logic       powered_down,         // device in any power-down
  output logic [7:0] reg0_value            // register 0 contents
);
  //////////////////////////////////////////////////////////////////////////
  ssp_pkg::ssp_pins_t pins;
  ssp_pkg::ssp_pins_t raw;
  logic ce_meta_r;
  logic ce_r;
  assign raw = '{sclk: serial_clk, sel_n: serial_select_n, sdio: sdio_in};
  ssp_sync u_sync (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pins_in  (raw),
    .pins_out (pins)
  );
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ce_meta_r <= 1'b0;
      ce_r      <= 1'b0;
    end else begin
      ce_meta_r <= chip_en;
      ce_r      <= ce_meta_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ssp_pkg::ssp_state_t        state;
    logic                       sclk_d;
    logic [4:0]                 cnt;
    logic [`SSP_HDR_BITS-1:0]   hdr;
    logic [`SSP_DATA_W-1:0]     shf;
    logic [`SSP_DATA_W-1:0]     rdat;
    logic                       rd;
    logic                       drv;
    logic                       dout;
  } ssp_st_t;
  ssp_st_t st_r;
  ssp_st_t st_nxt;
  logic [`SSP_DATA_W-1:0] regs_r [`SSP_NREGS];
  logic                   wr_en;
  logic [3:0]             wr_idx;
  logic [`SSP_DATA_W-1:0] wr_val;
  logic                   rise;
  logic                   fall;
  logic                   four_wire;
  assign rise = pins.sclk & ~st_r.sclk_d;
  assign fall = ~pins.sclk & st_r.sclk_d;
  assign four_wire = regs_r[0][`SSP_CFG_4WIRE];
  function automatic logic [3:0] ssp_idx(input logic [`SSP_HDR_BITS-1:0] h);
    ssp_idx = h[3:0];
  endfunction
  always_comb begin
    st_nxt = st_r;
    st_nxt.sclk_d = pins.sclk;
    wr_en  = 1'b0;
    wr_idx = ssp_idx(st_r.hdr);
    wr_val = {st_r.shf[`SSP_DATA_W-2:0], pins.sdio};
    if (pins.sel_n) begin
      st_nxt.state = ssp_pkg::SSP_IDLE;
      st_nxt.drv   = 1'b0;
      st_nxt.cnt   = 5'h00;
    end else begin
      case (st_r.state)
        ssp_pkg::SSP_IDLE: begin
          st_nxt.state = ssp_pkg::SSP_HDR;
          st_nxt.cnt   = 5'h00;
          st_nxt.rd    = 1'b0;
        end
        ssp_pkg::SSP_HDR: begin
          if (rise) begin
            st_nxt.hdr = {st_r.hdr[`SSP_HDR_BITS-2:0], pins.sdio};
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == 5'(`SSP_HDR_BITS - 1)) begin
              st_nxt.state = ssp_pkg::SSP_DATA;
              st_nxt.rd    = st_r.hdr[`SSP_HDR_BITS-2];
              st_nxt.rdat  = regs_r[ssp_idx({st_r.hdr[`SSP_HDR_BITS-2:0], pins.sdio})];
            end
          end
        end
        ssp_pkg::SSP_DATA: begin
          if (fall && st_r.rd) begin
            st_nxt.drv  = 1'b1;
            st_nxt.dout = st_r.rdat[`SSP_DATA_W-1];
            st_nxt.rdat = {st_r.rdat[`SSP_DATA_W-2:0], 1'b0};
          end
          if (rise) begin
            st_nxt.shf = wr_val;
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == 5'(`SSP_FRAME_BITS - 1)) begin
              st_nxt.state = ssp_pkg::SSP_DONE;
              wr_en = ~st_r.rd;
            end
          end
        end
        default: begin
          if (fall)
            st_nxt.drv = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= '{state: ssp_pkg::SSP_IDLE, sclk_d: 1'b0, cnt: 5'h00, hdr: '0,
                shf: '0, rdat: '0, rd: 1'b0, drv: 1'b0, dout: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // registers cleared while chip enable is low
  always_ff @(posedge clk) begin
    if (sys_rst || !ce_r) begin
      for (int i = 0; i < `SSP_NREGS; i++)
        regs_r[i] <= `SSP_REG_RST;
    end else if (wr_en) begin
      regs_r[wr_idx] <= wr_val;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sdio_out             <= 1'b0;
      sdio_oe              <= 1'b0;
      serial_out_line      <= 1'b0;
      serial_out_oe        <= 1'b0;
      global_powerdown_bit <= 1'b0;
      powered_down         <= 1'b1;
      reg0_value           <= 8'h00;
    end else begin
      sdio_out        <= st_nxt.dout;
      sdio_oe         <= st_nxt.drv & ~four_wire & ~pins.sel_n;
      serial_out_line <= st_nxt.dout;
      serial_out_oe   <= st_nxt.drv & four_wire & ~pins.sel_n;
      global_powerdown_bit <= regs_r[0][`SSP_CFG_PDOWN];
      powered_down    <= ~ce_r | regs_r[0][`SSP_CFG_PDOWN];
      reg0_value      <= regs_r[0];
    end
  end
  //////////////////////////////////////////////////////////////////////////
  a_so_hiz_3w: assert property (@(posedge clk) disable iff (sys_rst)
    !four_wire |=> !serial_out_oe || $past(four_wire, 1) == 1'b1)
    else $error("serial out driven in three-wire mode");
  a_so_off_sel: assert property (@(posedge clk) disable iff (sys_rst)
    pins.sel_n |=> !serial_out_oe && !sdio_oe)
    else $error("output driven with select high");
  a_no_both_oe: assert property (@(posedge clk) disable iff (sys_rst)
    !(sdio_oe && serial_out_oe))
    else $error("both lines driven");
  a_idle_on_sel: assert property (@(posedge clk) disable iff (sys_rst)
    pins.sel_n |=> st_r.state == ssp_pkg::SSP_IDLE)
    else $error("burst state outside select");
  a_shift_rise: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == ssp_pkg::SSP_HDR && !pins.sel_n && rise) |=> st_r.hdr[0] == $past(pins.sdio))
    else $error("header bit not sampled");
  a_dout_fall: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.drv && !fall) |=> st_r.dout == $past(st_r.dout) || $past(pins.sel_n))
    else $error("read data changed off falling edge");
  a_ce_clear: assert property (@(posedge clk) disable iff (sys_rst)
    !ce_r |=> regs_r[0] == 8'h00)
    else $error("registers not cleared by chip enable");
  a_4w_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (st_nxt.drv && four_wire && !pins.sel_n) |=> serial_out_oe)
    else $error("four-wire read not on serial out");
  //////////////////////////////////////////////////////////////////////////
  // three-wire read must actually turn the data line around
  a_sdio_3w_drive: assert property (@(posedge clk) disable iff (sys_rst)
    (st_nxt.drv && !four_wire && !pins.sel_n) |=> sdio_oe)
    else $error("three-wire read not on data line");
  // the driven level is always the current read bit
  a_sdio_out_bit: assert property (@(posedge clk) disable iff (sys_rst)
    sdio_oe |-> sdio_out == st_r.dout)
    else $error("data line shows wrong read bit");
  a_so_out_bit: assert property (@(posedge clk) disable iff (sys_rst)
    serial_out_oe |-> serial_out_line == st_r.dout)
    else $error("serial out shows wrong read bit");
  // only a read frame may ever drive; a write frame keeps the line an input
  a_oe_only_rd: assert property (@(posedge clk) disable iff (sys_rst)
    sdio_oe |-> st_r.rd)
    else $error("data line driven during write");
  a_data_from_sdio: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == ssp_pkg::SSP_DATA && !pins.sel_n && rise) |=> st_r.shf[0] == $past(pins.sdio))
    else $error("data bit not taken from data line");
  // power-down bit alone must not disturb stored contents
  a_pd_keep_regs: assert property (@(posedge clk) disable iff (sys_rst)
    (ce_r && !wr_en) |=> regs_r[0] == $past(regs_r[0]))
    else $error("register changed without a write");
  a_pdn_on_ce: assert property (@(posedge clk) disable iff (sys_rst)
    !ce_r |=> powered_down)
    else $error("chip enable low not powered down");
  // a write commits only inside a burst, never on select release
  a_wr_in_burst: assert property (@(posedge clk) disable iff (sys_rst)
    wr_en |-> !pins.sel_n)
    else $error("write outside burst");
  a_idle_no_drv: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.state == ssp_pkg::SSP_IDLE |-> !st_r.drv)
    else $error("drive left on in idle");
endmodule

// ---- design/ssp_regs.svh ----
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// frame: 1 rw bit (1 = read), 15 address bits, then 8 data bits
`define SSP_ADDR_W      15
`define SSP_DATA_W      8
`define SSP_FRAME_BITS  24
`define SSP_HDR_BITS    16
`define SSP_NREGS       16
`define SSP_REG_RST     8'h00
// register 0 bit layout (device-local)
`define SSP_CFG_ADDR    4'h0
`define SSP_CFG_4WIRE   3
`define SSP_CFG_PDOWN   0
`endif

// ---- design/ssp_sync.sv ----
`timescale 1ns/1ps
// two-flop synchroniser for the pin group
module ssp_sync (
  input  wire logic              clk,     // system clock
  input  wire logic              sys_rst, // synchronous reset
  input  wire ssp_pkg::ssp_pins_t pins_in, // raw pins
  output ssp_pkg::ssp_pins_t     pins_out // synchronised pins
);
  ssp_pkg::ssp_pins_t meta_r;
  ssp_pkg::ssp_pins_t sync_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= '{sclk: 1'b0, sel_n: 1'b1, sdio: 1'b0};
      sync_r <= '{sclk: 1'b0, sel_n: 1'b1, sdio: 1'b0};
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
    end
  end
  assign pins_out = sync_r;
endmodule

// ---- verification/ssp_host_model.sv ----
`timescale 1ns/1ps
// host side of the serial port; serial clock idles low outside bursts
module ssp_host_model (
  input  wire logic clk,     // system clock
  input  wire logic line,    // resolved data line
  input  wire logic so_line, // separate output value
  input  wire logic so_oe,   // separate output enable
  output logic      sclk,    // serial clock
  output logic      sel_n,   // burst select, active low
  output logic      drv,     // data line drive value
  output logic      drv_oe   // data line drive enable
);
  logic so_seen = 1'b0;
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    drv = 1'b0;
    drv_oe = 1'b0;
  end
  always @(posedge clk) if (!sel_n && so_oe) so_seen <= 1'b1;
  ////////////////////////////////////////////////////////////////
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [23:0] f, input logic four, output logic [7:0] rd);
    so_seen = 1'b0;
    @(posedge clk);
    #1;
    sel_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      drv = f[i];
      drv_oe = !(f[23] && i < 8); // released for read data
      half();
      sclk = 1'b1;
      if (i < 8) rd[i] = four ? so_line : line;
      half();
      sclk = 1'b0;
    end
    sel_n = 1'b1;
    drv_oe = 1'b0;
    half();
  endtask
endmodule

// ---- verification/ssp_port_tb.sv ----
`timescale 1ns/1ps
module ssp_port_tb;
  logic       clk = 0, sys_rst = 1, chip_en = 1, idle_pat = 0, line;
  logic       sclk, sel_n, drv, drv_oe, sdio_out, sdio_oe, so_line, so_oe, gpd, pdn;
  logic [7:0] reg0, rd;
  int         mismatches = 0;
  int         compares = 0;
  always #50 clk = ~clk;
  // undriven line toggles so a stale value never passes
  always @(posedge clk) idle_pat <= ~idle_pat;
  assign line = sdio_oe ? sdio_out : (drv_oe ? drv : idle_pat);
  ssp_port u_ssp_port (.clk(clk), .sys_rst(sys_rst), .chip_en(chip_en), .serial_clk(sclk),
    .serial_select_n(sel_n), .sdio_in(line), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_out_line(so_line), .serial_out_oe(so_oe), .global_powerdown_bit(gpd),
    .powered_down(pdn), .reg0_value(reg0));
  ssp_host_model u_ssp_host_model (.clk(clk), .line(line), .so_line(so_line), .so_oe(so_oe),
    .sclk(sclk), .sel_n(sel_n), .drv(drv), .drv_oe(drv_oe));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [23:0] f);
    u_ssp_host_model.xfer(f, 1'b0, rd);
    repeat (4) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_data_line();
    wr(24'h0005a5);
    u_ssp_host_model.xfer(24'h800500, 1'b0, rd);
    chk(rd, 8'ha5);
    chk({7'h00, u_ssp_host_model.so_seen}, 8'h00);
  endtask
  task automatic t_powerdown_bit();
    wr(24'h000001);
    chk({gpd, pdn, reg0[5:0]}, 8'hc1);
    u_ssp_host_model.xfer(24'h800500, 1'b0, rd);
    chk(rd, 8'ha5);
  endtask
  task automatic t_four_wire();
    wr(24'h000008);
    u_ssp_host_model.xfer(24'h800500, 1'b1, rd);
    chk(rd, 8'ha5);
    chk({7'h00, u_ssp_host_model.so_seen}, 8'h01);
    chk({7'h00, so_oe}, 8'h00);
  endtask
  task automatic t_chip_en();
    chip_en = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({pdn, reg0[6:0]}, 8'h80);
    chip_en = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    u_ssp_host_model.xfer(24'h800500, 1'b0, rd);
    chk(rd, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk({sdio_oe, so_oe, gpd, reg0[4:0]}, 8'h00);
    t_data_line();
    t_powerdown_bit();
    t_four_wire();
    t_chip_en();
    wrap_up();
  end
  initial begin
    #1000000;
    mismatches++;
    wrap_up();
  end
endmodule
